/* core/rss_gap_timer.sv */
// Millisecond gap timer: a divider makes a 1 ms enable pulse and a
// down counter counts those pulses. Assumes one clock, sync start.
`timescale 1ns/1ps
`include "rss_map.svh"

module rss_gap_timer
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = `RSS_TICK_CYCLES,
  parameter int MS_W        = 6
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  input  wire logic            start_i,
  input  wire logic [MS_W-1:0] gap_ms_i,
  output logic                 done_o
);

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  logic             busy_r;
  logic             busy_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [MS_W-1:0]  ms_r;
  logic [MS_W-1:0]  ms_nxt;
  logic             tick;

  assign tick   = busy_r && (div_r == DIV_LAST);
  // Last tick of the last millisecond closes the gap
  assign done_o = tick && (ms_r == MS_W'(1));

  always_comb begin
    busy_nxt = busy_r;
    div_nxt  = div_r;
    ms_nxt   = ms_r;
    if (start_i) begin
      // Restart realigns the divider so every gap is exact
      busy_nxt = (gap_ms_i != '0);
      div_nxt  = '0;
      ms_nxt   = gap_ms_i;
    end else if (busy_r) begin
      div_nxt = tick ? '0 : div_r + DIV_W'(1);
      if (tick) begin
        ms_nxt = ms_r - MS_W'(1);
        if (done_o) begin
          busy_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      div_r  <= '0;
      ms_r   <= '0;
    end else begin
      busy_r <= busy_nxt;
      div_r  <= div_nxt;
      ms_r   <= ms_nxt;
    end
  end

endmodule : rss_gap_timer

/* core/rss_map.svh */
// Address map, reset values, field positions and timing constants
// for the rail strobe sequencer. Definitions only.
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

`define RSS_ADDR_DELAYS      8'h20
`define RSS_ADDR_PD_CFG      8'h21
`define RSS_ADDR_MAIN_A      8'h22
`define RSS_ADDR_MAIN_B      8'h23
`define RSS_ADDR_BACKUP      8'h24
`define RSS_ADDR_CMD         8'h28
`define RSS_ADDR_STATUS      8'h29

`define RSS_RST_ZERO         8'h00
`define RSS_RST_MAIN_A       8'h56
`define RSS_RST_MAIN_B       8'h45

`define RSS_PD_CFG_MASK      8'h81
`define RSS_BACKUP_MASK      8'h33
`define RSS_MULT_BIT         7
`define RSS_NINTH_BIT        0
`define RSS_CMD_UP_BIT       0
`define RSS_CMD_DN_BIT       1
`define RSS_STAT_BUSY_BIT    7
`define RSS_STAT_ON_BIT      4

`define RSS_SLOT_MAIN_LO     4'h3
`define RSS_SLOT_MAIN_HI     4'hA
`define RSS_SLOT_BK_LO       2'h1
`define RSS_SLOT_BK_HI       2'h2
`define RSS_STROBE_FIRST     4'h1
`define RSS_STROBE_BK_LAST   4'h2
`define RSS_STROBE_MAIN_FIRST 4'h3
`define RSS_STROBE_LAST      4'hA

`define RSS_GAP_SHORT_MS     6'h02
`define RSS_GAP_LONG_MS      6'h05
`define RSS_PD_FACTOR        6'h0A
`define RSS_CLK_PERIOD_NS    50
`define RSS_TICK_NS          1000000
`define RSS_TICK_CYCLES      (`RSS_TICK_NS / `RSS_CLK_PERIOD_NS)

`endif

/* core/rss_pkg.sv */
// Types shared by the rail strobe sequencer files.
// Assumes rss_map.svh supplies all numeric constants.
package rss_pkg;

  typedef struct packed {
    logic backup_io_rail;
    logic backup_core_rail;
    logic buck_boost_rail;
    logic third_buck_rail;
    logic second_buck_rail;
    logic first_buck_rail;
  } rss_rails_s;

  typedef enum logic [2:0] {
    RSS_OFF,
    RSS_UP_STROBE,
    RSS_UP_GAP,
    RSS_ON,
    RSS_DN_STROBE,
    RSS_DN_GAP
  } rss_state_e;

  typedef logic [3:0] rss_strobe_t;

endpackage : rss_pkg

/* core/rss_sequencer.sv */
// Rail strobe sequencer: register file, strobe state machine and
// rail enables. Assumes a plain register port with one-cycle strobes
// and the freshness seal flag synchronous to ref_clk_i.
//
// Overview of operation
// - Power-down gaps are ten times longer when the multiplier bit is set.
// - Power-up gaps never use the multiplier.
// - Gap between strobes nine and ten is 2 ms or 5 ms by its bit.
// - A 4-bit slot of 3h to Ah enables its rail at that strobe.
// - 4-bit slot codes 0h to 2h and Bh to Fh leave the rail alone.
// - Backup slot code 1h enables at strobe one, 2h at strobe two.
// - Backup slot codes 0h and 3h leave the backup rail alone.
// - Strobes one and two run only while the seal flag is 0.
// - Backup rails are never disabled once the seal is broken.
// - First buck pair slot register resets to 0x56.
// - Second buck pair slot register resets to 0x45.
// - Reserved bits are read-only and read as zero.
// - Gaps after strobes one to eight are 2 ms or 5 ms by their bits.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "rss_map.svh"

module rss_sequencer
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = `RSS_TICK_CYCLES,
  parameter int ADDR_W      = 8,
  parameter int DATA_W      = 8
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              freshness_seal_flag_i,
  output rss_rails_s             rail_en_o,
  output logic                   seq_busy_o
);

  localparam int MS_W = 6;

  // Register file state
  logic [7:0]       delays_r;
  logic [7:0]       delays_nxt;
  logic             powerdown_delay_multiplier_r;
  logic             powerdown_delay_multiplier_nxt;
  logic             ninth_gap_select_r;
  logic             ninth_gap_select_nxt;
  logic [7:0]       main_buck_pair_a_slots_r;
  logic [7:0]       main_buck_pair_a_slots_nxt;
  logic [7:0]       main_buck_pair_b_slots_r;
  logic [7:0]       main_buck_pair_b_slots_nxt;
  logic [7:0]       backup_rail_slots_r;
  logic [7:0]       backup_rail_slots_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Sequencer state
  rss_state_e       state_r;
  rss_state_e       state_nxt;
  rss_strobe_t      strobe_r;
  rss_strobe_t      strobe_nxt;
  rss_rails_s       rails_r;
  rss_rails_s       rails_nxt;

  logic             cmd_up;
  logic             cmd_dn;
  logic             tmr_start;
  logic [MS_W-1:0]  tmr_ms;
  logic             tmr_done;
  logic [8:0]       gap_bits;
  rss_rails_s       hits;

  // Main rail slot decode, used for all four main rails
  function automatic logic main_hit(input logic [3:0] slot,
                                    input rss_strobe_t strobe);
    main_hit = (slot >= `RSS_SLOT_MAIN_LO) &&
               (slot <= `RSS_SLOT_MAIN_HI) &&
               (slot == strobe);
  endfunction : main_hit

  // Backup rail slot decode: codes double as the strobe number
  function automatic logic backup_hit(input logic [1:0] slot,
                                      input rss_strobe_t strobe);
    backup_hit = (slot >= `RSS_SLOT_BK_LO) &&
                 (slot <= `RSS_SLOT_BK_HI) &&
                 ({2'h0, slot} == strobe);
  endfunction : backup_hit

  // Gap length in ms; the factor applies only on the way down
  function automatic logic [MS_W-1:0] gap_ms(input logic long_sel,
                                             input logic scale);
    logic [MS_W-1:0] base;
    base = long_sel ? `RSS_GAP_LONG_MS : `RSS_GAP_SHORT_MS;
    gap_ms = scale ? MS_W'(base * `RSS_PD_FACTOR) : base;
  endfunction : gap_ms

  // Write strobes for the self-clearing command register
  assign cmd_up = reg_write_i && (reg_addr_i == `RSS_ADDR_CMD) &&
                  reg_wdata_i[`RSS_CMD_UP_BIT];
  assign cmd_dn = reg_write_i && (reg_addr_i == `RSS_ADDR_CMD) &&
                  reg_wdata_i[`RSS_CMD_DN_BIT];

  // ---------------- Register file ----------------
  always_comb begin
    delays_nxt                     = delays_r;
    powerdown_delay_multiplier_nxt = powerdown_delay_multiplier_r;
    ninth_gap_select_nxt           = ninth_gap_select_r;
    main_buck_pair_a_slots_nxt     = main_buck_pair_a_slots_r;
    main_buck_pair_b_slots_nxt     = main_buck_pair_b_slots_r;
    backup_rail_slots_nxt          = backup_rail_slots_r;
    rdata_nxt                      = '0;
    if (reg_write_i) begin
      if (reg_addr_i == `RSS_ADDR_DELAYS) begin
        delays_nxt = reg_wdata_i[7:0];
      end else if (reg_addr_i == `RSS_ADDR_PD_CFG) begin
        powerdown_delay_multiplier_nxt = reg_wdata_i[`RSS_MULT_BIT];
        ninth_gap_select_nxt           = reg_wdata_i[`RSS_NINTH_BIT];
      end else if (reg_addr_i == `RSS_ADDR_MAIN_A) begin
        main_buck_pair_a_slots_nxt = reg_wdata_i[7:0];
      end else if (reg_addr_i == `RSS_ADDR_MAIN_B) begin
        main_buck_pair_b_slots_nxt = reg_wdata_i[7:0];
      end else if (reg_addr_i == `RSS_ADDR_BACKUP) begin
        // Reserved bits never store a one
        backup_rail_slots_nxt = reg_wdata_i[7:0] & `RSS_BACKUP_MASK;
      end
    end
    if (reg_read_i) begin
      if (reg_addr_i == `RSS_ADDR_DELAYS) begin
        rdata_nxt[7:0] = delays_r;
      end else if (reg_addr_i == `RSS_ADDR_PD_CFG) begin
        rdata_nxt[`RSS_MULT_BIT]  = powerdown_delay_multiplier_r;
        rdata_nxt[`RSS_NINTH_BIT] = ninth_gap_select_r;
      end else if (reg_addr_i == `RSS_ADDR_MAIN_A) begin
        rdata_nxt[7:0] = main_buck_pair_a_slots_r;
      end else if (reg_addr_i == `RSS_ADDR_MAIN_B) begin
        rdata_nxt[7:0] = main_buck_pair_b_slots_r;
      end else if (reg_addr_i == `RSS_ADDR_BACKUP) begin
        rdata_nxt[7:0] = backup_rail_slots_r & `RSS_BACKUP_MASK;
      end else if (reg_addr_i == `RSS_ADDR_STATUS) begin
        rdata_nxt[`RSS_STAT_BUSY_BIT] = seq_busy_o;
        rdata_nxt[`RSS_STAT_ON_BIT]   = (state_r == RSS_ON);
        rdata_nxt[3:0] = strobe_r;
      end
      // Command register and unmapped addresses read as zero
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      delays_r                     <= `RSS_RST_ZERO;
      powerdown_delay_multiplier_r <= 1'b0;
      ninth_gap_select_r           <= 1'b0;
      main_buck_pair_a_slots_r     <= `RSS_RST_MAIN_A;
      main_buck_pair_b_slots_r     <= `RSS_RST_MAIN_B;
      backup_rail_slots_r          <= `RSS_RST_ZERO;
      rdata_r                      <= '0;
    end else begin
      delays_r                     <= delays_nxt;
      powerdown_delay_multiplier_r <= powerdown_delay_multiplier_nxt;
      ninth_gap_select_r           <= ninth_gap_select_nxt;
      main_buck_pair_a_slots_r     <= main_buck_pair_a_slots_nxt;
      main_buck_pair_b_slots_r     <= main_buck_pair_b_slots_nxt;
      backup_rail_slots_r          <= backup_rail_slots_nxt;
      rdata_r                      <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ---------------- Strobe decode ----------------
  // Bit k-1 holds the gap that follows strobe k
  assign gap_bits = {ninth_gap_select_r, delays_r};

  always_comb begin
    hits = '0;
    hits.first_buck_rail  = main_hit(main_buck_pair_a_slots_r[3:0],
                                     strobe_r);
    hits.second_buck_rail = main_hit(main_buck_pair_a_slots_r[7:4],
                                     strobe_r);
    hits.third_buck_rail  = main_hit(main_buck_pair_b_slots_r[3:0],
                                     strobe_r);
    hits.buck_boost_rail  = main_hit(main_buck_pair_b_slots_r[7:4],
                                     strobe_r);
    hits.backup_core_rail = backup_hit(backup_rail_slots_r[1:0],
                                       strobe_r);
    hits.backup_io_rail   = backup_hit(backup_rail_slots_r[5:4],
                                       strobe_r);
  end

  // ---------------- Sequencer ----------------
  // Commands are only taken in a settled state; a request that
  // arrives mid-sequence is dropped so the rails never half-reverse.
  always_comb begin
    state_nxt  = state_r;
    strobe_nxt = strobe_r;
    rails_nxt  = rails_r;
    tmr_start  = 1'b0;
    tmr_ms     = '0;
    case (state_r)
      RSS_OFF: begin
        if (cmd_up) begin
          strobe_nxt = `RSS_STROBE_FIRST;
          state_nxt  = RSS_UP_STROBE;
        end
      end
      RSS_UP_STROBE: begin
        if (freshness_seal_flag_i &&
            (strobe_r <= `RSS_STROBE_BK_LAST)) begin
          // Seal broken: strobes one and two and their gaps vanish
          strobe_nxt = `RSS_STROBE_MAIN_FIRST;
        end else begin
          rails_nxt = rails_r | hits;
          if (strobe_r == `RSS_STROBE_LAST) begin
            state_nxt = RSS_ON;
          end else begin
            tmr_start = 1'b1;
            tmr_ms    = gap_ms(gap_bits[strobe_r - 4'h1], 1'b0);
            state_nxt = RSS_UP_GAP;
          end
        end
      end
      RSS_UP_GAP: begin
        if (tmr_done) begin
          strobe_nxt = strobe_r + 4'h1;
          state_nxt  = RSS_UP_STROBE;
        end
      end
      RSS_ON: begin
        if (cmd_dn) begin
          strobe_nxt = `RSS_STROBE_LAST;
          state_nxt  = RSS_DN_STROBE;
        end
      end
      RSS_DN_STROBE: begin
        if (freshness_seal_flag_i &&
            (strobe_r <= `RSS_STROBE_BK_LAST)) begin
          // Backup domain stays up for good once the seal is broken
          state_nxt = RSS_OFF;
        end else begin
          rails_nxt = rails_r & ~hits;
          if (freshness_seal_flag_i) begin
            rails_nxt.backup_core_rail = rails_r.backup_core_rail;
            rails_nxt.backup_io_rail   = rails_r.backup_io_rail;
          end
          if (strobe_r == `RSS_STROBE_FIRST) begin
            state_nxt = RSS_OFF;
          end else begin
            tmr_start = 1'b1;
            // Gap between strobe k-1 and k, stretched tenfold when the multiplier bit is set
            tmr_ms    = gap_ms(gap_bits[strobe_r - 4'h2],
                               powerdown_delay_multiplier_r);
            state_nxt = RSS_DN_GAP;
          end
        end
      end
      RSS_DN_GAP: begin
        if (tmr_done) begin
          strobe_nxt = strobe_r - 4'h1;
          state_nxt  = RSS_DN_STROBE;
        end
      end
      default: begin
        state_nxt = RSS_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r  <= RSS_OFF;
      strobe_r <= '0;
      rails_r  <= '0;
    end else begin
      state_r  <= state_nxt;
      strobe_r <= strobe_nxt;
      rails_r  <= rails_nxt;
    end
  end

  rss_gap_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .MS_W        (MS_W)
  ) u_gap_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (tmr_start),
    .gap_ms_i  (tmr_ms),
    .done_o    (tmr_done)
  );

  assign rail_en_o  = rails_r;
  assign seq_busy_o = (state_r != RSS_OFF) && (state_r != RSS_ON);

endmodule : rss_sequencer

/* verif/rss_sequencer_properties.sv */
// Port checker for the rail strobe sequencer.
// Assumes it is bound to rss_sequencer: one clock, async high reset.
`timescale 1ns/1ps

module rss_sequencer_properties
  import rss_pkg::*;
#(
  parameter int TICK_CYCLES = 20000
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       freshness_seal_flag_i,
  input wire rss_rails_s rail_en_o,
  input wire logic       seq_busy_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_rdata_idle_zero: assert property (
    !$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data nonzero outside a read cycle");
  a_pd_reserved_zero: assert property (
    $past(reg_read_i) && $past(reg_addr_i) == 8'h21
    |-> (reg_rdata_o & 8'h7E) == 8'h00)
    else $error("reserved bits of the factor register read nonzero");
  a_bk_reserved_zero: assert property (
    $past(reg_read_i) && $past(reg_addr_i) == 8'h24
    |-> (reg_rdata_o & 8'hCC) == 8'h00)
    else $error("reserved bits of the backup slot register read nonzero");
  a_unmapped_zero: assert property (
    $past(reg_read_i) && !($past(reg_addr_i) inside
    {8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h29}) |-> reg_rdata_o == 8'h00)
    else $error("unmapped or write-only address read nonzero");
  a_rails_idle_still: assert property (
    !seq_busy_o && !$past(seq_busy_o) |-> $stable(rail_en_o))
    else $error("rail enables changed with no sequence running");
  a_core_held_sealed: assert property (
    freshness_seal_flag_i && $past(freshness_seal_flag_i)
    && $past(rail_en_o.backup_core_rail) |-> rail_en_o.backup_core_rail)
    else $error("backup core rail dropped after seal broken");
  a_io_held_sealed: assert property (
    freshness_seal_flag_i && $past(freshness_seal_flag_i)
    && $past(rail_en_o.backup_io_rail) |-> rail_en_o.backup_io_rail)
    else $error("backup io rail dropped after seal broken");
  a_core_rise_fresh: assert property (
    $rose(rail_en_o.backup_core_rail) |-> !$past(freshness_seal_flag_i))
    else $error("backup core rail enabled with seal broken");
  a_io_rise_fresh: assert property (
    $rose(rail_en_o.backup_io_rail) |-> !$past(freshness_seal_flag_i))
    else $error("backup io rail enabled with seal broken");
endmodule : rss_sequencer_properties

bind rss_sequencer rss_sequencer_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .freshness_seal_flag_i(freshness_seal_flag_i),
  .rail_en_o(rail_en_o), .seq_busy_o(seq_busy_o)
);

/* verif/test_rail_strobe_sequencer.sv */
// Self-checking bench for the rail strobe sequencer.
// Assumes a short millisecond tick so whole sequences run quickly.
`timescale 1ns/1ps

module test_rail_strobe_sequencer;
  import rss_pkg::*;
  localparam int TICK = 4;
  logic       ref_clk_i             = 1'b0;
  logic       rst_i                 = 1'b1;
  logic [7:0] reg_addr_i            = 8'h00;
  logic [7:0] reg_wdata_i           = 8'h00;
  logic       reg_write_i           = 1'b0;
  logic       reg_read_i            = 1'b0;
  logic       freshness_seal_flag_i = 1'b0;
  logic [7:0] reg_rdata_o;
  rss_rails_s rail_en_o;
  logic       seq_busy_o;
  int         fail_count            = 0;
  int         n_tests               = 0;
  int         ev[6];
  int         t_cyc, t_up0, t_dn0;

  rss_sequencer #(.TICK_CYCLES(TICK)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .freshness_seal_flag_i(freshness_seal_flag_i),
    .rail_en_o(rail_en_o), .seq_busy_o(seq_busy_o)
  );

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_write_i <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rd_chk

  // Records the cycle of each rail change; length bounded by a cap
  task automatic run(input logic [7:0] cmd);
    logic [5:0] prev;
    prev = rail_en_o;
    ev = '{default: 0};
    t_cyc = 0;
    wr(8'h28, cmd);
    do begin
      @(posedge ref_clk_i);
      #1;
      t_cyc++;
      for (int i = 0; i < 6; i++) begin
        if (rail_en_o[i] !== prev[i]) ev[i] = t_cyc;
      end
      prev = rail_en_o;
    end while (seq_busy_o === 1'b1 && t_cyc < 5000);
    if (t_cyc >= 5000) begin
      fail_count++;
      end_of_test();
    end
  endtask : run

  task automatic seal(input logic v);
    @(posedge ref_clk_i);
    freshness_seal_flag_i <= v;
  endtask : seal

  task automatic sc_regs();
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h21, 8'h00);
    rd_chk(8'h22, 8'h56);
    rd_chk(8'h23, 8'h45);
    rd_chk(8'h24, 8'h00);
    rd_chk(8'h2A, 8'h00);
    wr(8'h21, 8'hFF);
    rd_chk(8'h21, 8'h81);
    wr(8'h24, 8'hFF);
    rd_chk(8'h24, 8'h33);
    wr(8'h21, 8'h00);
    wr(8'h24, 8'h21);
  endtask : sc_regs

  task automatic sc_default();
    run(8'h01);
    chk({2'b00, rail_en_o}, 8'h3F);
    chk({7'h00, ev[4] < ev[5] && ev[5] < ev[3]}, 8'h01);
    chk({7'h00, ev[3] < ev[1] && ev[1] == ev[2] && ev[2] < ev[0]}, 8'h01);
    t_up0 = t_cyc;
    rd_chk(8'h29, 8'h1A);
    run(8'h02);
    chk({2'b00, rail_en_o}, 8'h00);
    chk({7'h00, ev[0] < ev[1] && ev[1] == ev[2] && ev[2] < ev[3]}, 8'h01);
    chk({7'h00, ev[3] < ev[5] && ev[5] < ev[4]}, 8'h01);
    t_dn0 = t_cyc;
    rd_chk(8'h29, 8'h01);
  endtask : sc_default

  // Nine gaps each way: up 2 to 5 ms, down 2 ms to 5 ms times ten
  task automatic sc_delays();
    wr(8'h20, 8'hFF);
    wr(8'h21, 8'h81);
    run(8'h01);
    chk({7'h00, t_cyc - t_up0 == 27 * TICK}, 8'h01);
    run(8'h02);
    chk({7'h00, t_cyc - t_dn0 == 432 * TICK}, 8'h01);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
  endtask : sc_delays

  task automatic sc_seal();
    seal(1'b1);
    run(8'h01);
    chk({2'b00, rail_en_o}, 8'h0F);
    run(8'h02);
    chk({2'b00, rail_en_o}, 8'h00);
    seal(1'b0);
    run(8'h01);
    seal(1'b1);
    run(8'h02);
    chk({2'b00, rail_en_o}, 8'h30);
  endtask : sc_seal

  // Boundary codes 3h and Ah beside uncontrolled ones
  task automatic sc_unassigned();
    seal(1'b0);
    wr(8'h22, 8'hA2);
    wr(8'h23, 8'h3B);
    wr(8'h24, 8'h33);
    run(8'h01);
    chk({2'b00, rail_en_o}, 8'h3A);
    chk({7'h00, ev[3] < ev[1]}, 8'h01);
    run(8'h02);
    chk({2'b00, rail_en_o}, 8'h30);
  endtask : sc_unassigned

  // Reset in mid-sequence restores defaults; stray commands are dropped
  task automatic sc_reset();
    wr(8'h28, 8'h01);
    rd_chk(8'h29, 8'h81);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk({2'b00, rail_en_o}, 8'h00);
    rd_chk(8'h22, 8'h56);
    rd_chk(8'h23, 8'h45);
    wr(8'h28, 8'h02);
    rd_chk(8'h29, 8'h00);
  endtask : sc_reset

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    sc_regs();
    sc_default();
    sc_delays();
    sc_seal();
    sc_unassigned();
    sc_reset();
    end_of_test();
  end
endmodule : test_rail_strobe_sequencer
